// ==== lqrd_consts.vh ====
// Constants for the LC quadrature rotation decoder
`ifndef LQRD_CONSTS_VH
`define LQRD_CONSTS_VH

// ==========================================
// Clock and timing
`define LQRD_CLK_HZ       20000000
`define LQRD_CLK_NS       50
`define LQRD_CHARGE_NS    250
`define LQRD_CHARGE_CYC   ((`LQRD_CHARGE_NS + `LQRD_CLK_NS - 1) / `LQRD_CLK_NS)
`define LQRD_WINDOW_NS    39000
`define LQRD_WINDOW_CYC   (`LQRD_WINDOW_NS / `LQRD_CLK_NS)
`define LQRD_IDLE_HZ      12
`define LQRD_FAST_HZ      200
`define LQRD_IDLE_PERIOD  (`LQRD_CLK_HZ / `LQRD_IDLE_HZ)
`define LQRD_FAST_PERIOD  (`LQRD_CLK_HZ / `LQRD_FAST_HZ)
`define LQRD_QUIET_SAMPLES 64

// ==========================================
// Sensing and interval counter
`define LQRD_OSC_TARGET   22
`define LQRD_TDC_STEP     2

// ==========================================
// Quadrature states and reset values
`define LQRD_Q_S0         2'h0
`define LQRD_Q_S1         2'h1
`define LQRD_Q_S2         2'h3
`define LQRD_Q_S3         2'h2
`define LQRD_STATE_RST    2'h0

`endif

// ==== lqrd_lc_pair.sv ====
// Behavioural model of the two tank sensors above the half-metal disc
`timescale 1ns/1ps
module lqrd_lc_pair #(
  parameter FREE_OSC = 5,
  parameter DAMP_OSC = 1
) (
  input  wire logic       core_clk_i,
  input  wire logic [1:0] charge_n_i,
  input  wire logic [1:0] metal_i,
  output logic      [1:0] comp_o
);
  logic [7:0] ring [2] = '{8'h00, 8'h00};
  logic [1:0] last_n = 2'h3;

  // ==========================================
  // Ring-down, six clocks per oscillation so the sync stages see each level
  always @(posedge core_clk_i) begin
    last_n <= charge_n_i;
    for (int k = 0; k < 2; k++) begin
      if (charge_n_i[k] && !last_n[k])
        ring[k] <= 8'(6 * (metal_i[k] ? DAMP_OSC : FREE_OSC));
      else if (ring[k] != 8'h00)
        ring[k] <= ring[k] - 8'h01;
      comp_o[k] <= ring[k] % 6 > 2;
    end
  end
endmodule

// ==== lqrd_rotation_chk.sv ====
// Port-level assertions for the rotation decoder
`timescale 1ns/1ps
module lqrd_rotation_chk #(
  parameter CNT_W      = 32,
  parameter TDC_W      = 16,
  parameter WINDOW_CYC = 40
) (
  input wire logic             core_clk_i,
  input wire logic             rst_n_i,
  input wire logic [7:0]       charge_cycles_i,
  input wire logic [1:0]       charge_n_o,
  input wire logic [1:0]       sensor_pair_state_o,
  input wire logic [CNT_W-1:0] forward_step_count_o,
  input wire logic [CNT_W-1:0] backward_step_count_o,
  input wire logic [CNT_W-1:0] net_rotation_count_o,
  input wire logic             undersample_o,
  input wire logic             fast_rate_o,
  input wire logic             sample_done_o,
  input wire logic [TDC_W-1:0] interval_time_counter_o,
  input wire logic             interval_valid_o
);
  localparam int W_LO = WINDOW_CYC - 1;
  localparam int W_HI = WINDOW_CYC + 3;
  logic [1:0]       prev;
  logic             seen;
  logic [7:0]       low_cnt;
  wire  [1:0]       st      = sensor_pair_state_o;
  wire  [CNT_W-1:0] fc      = forward_step_count_o;
  wire  [CNT_W-1:0] bc      = backward_step_count_o;
  wire  [1:0]       fwd_nx  = {prev[0], ~prev[1]};
  wire  [1:0]       bwd_nx  = {~prev[0], prev[1]};
  wire  [7:0]       exp_len = charge_cycles_i == 8'h00 ? 8'h05 : charge_cycles_i;
  // First sample after reset only seeds the previous state
  wire              go      = sample_done_o && seen;
  wire              jump    = go && st == ~prev;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================
  // Helper state
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev    <= 2'h0;
      seen    <= 1'b0;
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= charge_n_o[0] ? 8'h00 : low_cnt + 8'h01;
      if (sample_done_o) begin
        prev <= st;
        seen <= 1'b1;
      end
    end
  end

  // ==========================================
  // Assertions
  chk_fwd_step: assert property (
    go && st == fwd_nx |-> fc == $past(fc) + 1 && bc == $past(bc))
    else $error("forward step not counted once");
  chk_bwd_step: assert property (
    go && st == bwd_nx |-> bc == $past(bc) + 1 && fc == $past(fc))
    else $error("backward step not counted once");
  chk_hold_still: assert property (
    go && st == prev |-> fc == $past(fc) && bc == $past(bc))
    else $error("count moved without a state change");
  chk_jump_flag: assert property (
    jump |-> (fc == $past(fc) && bc == $past(bc)) ##[0:1] undersample_o)
    else $error("two-step jump counted or not flagged");
  chk_jump_fast: assert property (jump |-> ##[0:2] fast_rate_o)
    else $error("jump did not raise sampling rate");
  chk_net_diff: assert property (
    sample_done_o |=> net_rotation_count_o == fc - bc)
    else $error("net count is not forward minus backward");
  chk_charge_len: assert property ($rose(charge_n_o[0]) |-> low_cnt == exp_len)
    else $error("charge pulse length wrong");
  chk_second_next: assert property (
    $rose(charge_n_o[0]) |-> ##[W_LO:W_HI] !charge_n_o[1])
    else $error("second sensor not charged after first window");
  chk_tdc_even: assert property (interval_valid_o |-> !interval_time_counter_o[0])
    else $error("interval count not in two-per-clock steps");
  cover property (go && st == fwd_nx);
  cover property (go && st == bwd_nx);
  cover property (jump);
  cover property (interval_valid_o);
endmodule

bind lqrd_rotation_decoder lqrd_rotation_chk #(
  .CNT_W(CNT_W), .TDC_W(TDC_W), .WINDOW_CYC(WINDOW_CYC)
) lqrd_rotation_chk_inst (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .charge_cycles_i(charge_cycles_i),
  .charge_n_o(charge_n_o), .sensor_pair_state_o(sensor_pair_state_o),
  .forward_step_count_o(forward_step_count_o), .backward_step_count_o(backward_step_count_o),
  .net_rotation_count_o(net_rotation_count_o), .undersample_o(undersample_o),
  .fast_rate_o(fast_rate_o), .sample_done_o(sample_done_o),
  .interval_time_counter_o(interval_time_counter_o), .interval_valid_o(interval_valid_o));

// ==== lqrd_rotation_decoder.v ====
// LC quadrature rotation decoder: sensor sequencing, decode and step counting
`timescale 1ns/1ps
`include "lqrd_consts.vh"

module lqrd_rotation_decoder #(
  parameter CNT_W         = 32,
  parameter TDC_W         = 16,
  parameter OSC_TARGET    = `LQRD_OSC_TARGET,
  parameter WINDOW_CYC    = `LQRD_WINDOW_CYC,
  parameter IDLE_PERIOD   = `LQRD_IDLE_PERIOD,
  parameter FAST_PERIOD   = `LQRD_FAST_PERIOD,
  parameter QUIET_SAMPLES = `LQRD_QUIET_SAMPLES
) (
  input  wire             core_clk_i,
  input  wire             rst_n_i,
  input  wire [1:0]       threshold_comparator_i,
  input  wire [7:0]       charge_cycles_i,
  input  wire             start_sel_i,
  input  wire             stop_sel_i,
  input  wire             single_shot_i,
  input  wire             arm_i,
  input  wire             clear_undersample_i,
  output reg  [1:0]       charge_n_o,
  output reg  [1:0]       sensor_pair_state_o,
  output reg  [CNT_W-1:0] forward_step_count_o,
  output reg  [CNT_W-1:0] backward_step_count_o,
  output reg  [CNT_W-1:0] net_rotation_count_o,
  output reg              undersample_o,
  output reg              fast_rate_o,
  output reg              sample_done_o,
  output reg  [TDC_W-1:0] interval_time_counter_o,
  output reg              interval_sensor_o,
  output reg              interval_valid_o
);

  // ==========================================
  // Sequencer states
  localparam [1:0] ST_WAIT   = 2'h0;
  localparam [1:0] ST_CHARGE = 2'h1;
  localparam [1:0] ST_WINDOW = 2'h2;
  localparam [1:0] ST_DECIDE = 2'h3;

  localparam [31:0] IDLE_RL  = IDLE_PERIOD - 1;
  localparam [31:0] FAST_RL  = FAST_PERIOD - 1;
  // Integer forms first, then cut to the register widths on purpose
  localparam integer WIN_I   = WINDOW_CYC - 1;
  localparam integer TGT_I   = OSC_TARGET;
  localparam integer CHG_I   = `LQRD_CHARGE_CYC;
  localparam integer QUIET_I = QUIET_SAMPLES - 1;
  localparam integer STEP_I  = `LQRD_TDC_STEP;
  localparam [15:0] WIN_RL   = WIN_I[15:0];
  localparam [7:0]  TARGET   = TGT_I[7:0];
  localparam [7:0]  DEF_CHG  = CHG_I[7:0];
  localparam [15:0] QUIET_RL = QUIET_I[15:0];
  localparam [TDC_W-1:0] TDC_STEP = STEP_I[TDC_W-1:0];

  // ==========================================
  // Comparator input synchronisers
  reg [1:0] sync1;
  reg [1:0] sync2;
  reg [1:0] sync3;
  reg [1:0] cmp_lvl;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1   <= 2'h0;
      sync2   <= 2'h0;
      sync3   <= 2'h0;
      cmp_lvl <= 2'h0;
    end else begin
      sync1 <= threshold_comparator_i;
      sync2 <= sync1;
      sync3 <= sync2;
      // Level accepted only once the later two stages agree
      cmp_lvl <= (sync2 & sync3) | (cmp_lvl & (sync2 | sync3));
    end
  end

  reg  sensor;
  wire agreed_hi;
  wire crossing;

  assign agreed_hi = sensor ? (sync2[1] & sync3[1]) : (sync2[0] & sync3[0]);
  assign crossing  = agreed_hi & ~(sensor ? cmp_lvl[1] : cmp_lvl[0]);

  // ==========================================
  // Sequencer and sensing
  reg [1:0]  state;
  reg [31:0] per_cnt;
  reg [7:0]  chg_cnt;
  reg [15:0] win_cnt;
  reg [7:0]  osc_cnt;
  reg [1:0]  bits;
  reg        tdc_run;
  reg        tdc_started;
  reg [TDC_W-1:0] tdc_cnt;
  reg        armed;
  reg        have_prev;
  reg [1:0]  prev;
  reg [15:0] quiet_cnt;

  wire [7:0] chg_len;
  wire [7:0] next_osc;
  wire       period_tick;

  // Zero would wrap to a 256-cycle pulse, so it falls back to the default
  assign chg_len     = (charge_cycles_i == 8'h00) ? DEF_CHG : charge_cycles_i;
  assign next_osc    = (osc_cnt == 8'hff) ? osc_cnt : osc_cnt + 8'h01;
  assign period_tick = (per_cnt == 32'h0000_0000);

  // ==========================================
  // Quadrature decode of the fresh sample
  function [1:0] fwd_of;
    input [1:0] s;
    begin
      case (s)
        `LQRD_Q_S0: fwd_of = `LQRD_Q_S1;
        `LQRD_Q_S1: fwd_of = `LQRD_Q_S2;
        `LQRD_Q_S2: fwd_of = `LQRD_Q_S3;
        default:    fwd_of = `LQRD_Q_S0;
      endcase
    end
  endfunction

  wire is_fwd;
  wire is_back;
  wire is_jump;
  wire changed;

  assign changed = have_prev & (bits != prev);
  assign is_fwd  = changed & (bits == fwd_of(prev));
  assign is_back = changed & (prev == fwd_of(bits));
  assign is_jump = changed & (bits == ~prev);

  wire jump_set;
  assign jump_set = (state == ST_DECIDE) & is_jump;

  // ==========================================
  // Sample period and sensor sequencing
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state       <= ST_WAIT;
      per_cnt     <= 32'h0000_0000;
      chg_cnt     <= 8'h00;
      win_cnt     <= 16'h0000;
      osc_cnt     <= 8'h00;
      sensor      <= 1'b0;
      bits        <= `LQRD_STATE_RST;
      charge_n_o  <= 2'h3;
    end else begin
      if (period_tick) begin
        // A jump in the same cycle must not reload the slow period
        per_cnt <= (fast_rate_o | jump_set) ? FAST_RL : IDLE_RL;
      end else if (jump_set && !fast_rate_o) begin
        // Cut a long idle wait short on undersampling
        per_cnt <= FAST_RL;
      end else begin
        per_cnt <= per_cnt - 32'h0000_0001;
      end
      case (state)
        ST_WAIT: begin
          if (period_tick) begin
            sensor     <= 1'b0;
            chg_cnt    <= chg_len - 8'h01;
            charge_n_o <= 2'h2;
            state      <= ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          if (chg_cnt == 8'h00) begin
            charge_n_o <= 2'h3;
            win_cnt    <= WIN_RL;
            osc_cnt    <= 8'h00;
            state      <= ST_WINDOW;
          end else begin
            chg_cnt <= chg_cnt - 8'h01;
          end
        end
        ST_WINDOW: begin
          if (crossing) begin
            osc_cnt <= next_osc;
          end
          if (win_cnt == 16'h0000) begin
            // Short of the target means the disc metal damped it
            if (sensor) begin
              bits[0] <= (osc_cnt < TARGET);
              state   <= ST_DECIDE;
            end else begin
              bits[1]    <= (osc_cnt < TARGET);
              sensor     <= 1'b1;
              chg_cnt    <= chg_len - 8'h01;
              charge_n_o <= 2'h1;
              state      <= ST_CHARGE;
            end
          end else begin
            win_cnt <= win_cnt - 16'h0001;
          end
        end
        ST_DECIDE: begin
          state <= ST_WAIT;
        end
        default: begin
          state <= ST_WAIT;
        end
      endcase
    end
  end

  // ==========================================
  // Interval time counter
  wire start_ev;
  wire stop_ev;
  wire win_end;
  wire capture_ok;

  assign start_ev = start_sel_i ? (state == ST_WINDOW) & crossing & ~tdc_started
                                : (state == ST_CHARGE) & (chg_cnt == 8'h00);
  assign stop_ev  = ~stop_sel_i & (state == ST_WINDOW) & crossing & (next_osc == TARGET);
  assign win_end  = (state == ST_WINDOW) & (win_cnt == 16'h0000);
  assign capture_ok = ~single_shot_i | armed;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdc_run                 <= 1'b0;
      tdc_started             <= 1'b0;
      tdc_cnt                 <= {TDC_W{1'b0}};
      armed                   <= 1'b0;
      interval_time_counter_o <= {TDC_W{1'b0}};
      interval_sensor_o       <= 1'b0;
      interval_valid_o        <= 1'b0;
    end else begin
      interval_valid_o <= 1'b0;
      if (start_ev) begin
        tdc_run     <= 1'b1;
        tdc_started <= 1'b1;
        tdc_cnt     <= {TDC_W{1'b0}};
      end else if (stop_ev) begin
        tdc_run <= 1'b0;
      end else if (tdc_run) begin
        // Two counts per rising clock edge, standing in for both edges
        tdc_cnt <= tdc_cnt + TDC_STEP;
      end
      if (win_end) begin
        tdc_run     <= 1'b0;
        tdc_started <= 1'b0;
        if (capture_ok) begin
          interval_time_counter_o <= tdc_cnt;
          interval_sensor_o       <= sensor;
          interval_valid_o        <= 1'b1;
        end
      end
      // A fresh arm wins over its own consumption
      if (arm_i) begin
        armed <= 1'b1;
      end else if (win_end && single_shot_i) begin
        armed <= 1'b0;
      end
    end
  end

  // ==========================================
  // Step accumulation and rate control
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      have_prev             <= 1'b0;
      prev                  <= `LQRD_STATE_RST;
      sensor_pair_state_o   <= `LQRD_STATE_RST;
      forward_step_count_o  <= {CNT_W{1'b0}};
      backward_step_count_o <= {CNT_W{1'b0}};
      net_rotation_count_o  <= {CNT_W{1'b0}};
      undersample_o         <= 1'b0;
      fast_rate_o           <= 1'b0;
      quiet_cnt             <= 16'h0000;
      sample_done_o         <= 1'b0;
    end else begin
      sample_done_o        <= 1'b0;
      net_rotation_count_o <= forward_step_count_o - backward_step_count_o;
      if (state == ST_DECIDE) begin
        sample_done_o       <= 1'b1;
        sensor_pair_state_o <= bits;
        prev                <= bits;
        have_prev           <= 1'b1;
        if (is_fwd) begin
          forward_step_count_o <= forward_step_count_o + 1'b1;
        end
        if (is_back) begin
          backward_step_count_o <= backward_step_count_o + 1'b1;
        end
        if (changed) begin
          fast_rate_o <= 1'b1;
          quiet_cnt   <= 16'h0000;
        end else if (quiet_cnt >= QUIET_RL) begin
          // Stay fast while an undersampling flag is still pending
          if (!undersample_o) begin
            fast_rate_o <= 1'b0;
          end
        end else begin
          quiet_cnt <= quiet_cnt + 16'h0001;
        end
      end
      // Set wins over a clear in the same cycle
      if (jump_set) begin
        undersample_o <= 1'b1;
      end else if (clear_undersample_i) begin
        undersample_o <= 1'b0;
      end
    end
  end

endmodule

// ==== lqrd_rotation_decoder_bench.sv ====
// Self-checking testbench for the rotation decoder
`timescale 1ns/1ps
module lqrd_rotation_decoder_bench;
  logic        core_clk_i = 0, rst_n_i = 0, start_sel_i = 0, stop_sel_i = 1;
  logic        single_shot_i = 0, arm_i = 0, clear_undersample_i = 0;
  logic [7:0]  charge_cycles_i = 8'h03;
  logic [1:0]  threshold_comparator_i, charge_n_o, sensor_pair_state_o, metal = 2'h0;
  logic [31:0] forward_step_count_o, backward_step_count_o, net_rotation_count_o;
  logic [15:0] interval_time_counter_o;
  logic        undersample_o, fast_rate_o, sample_done_o, interval_sensor_o, interval_valid_o;
  int          bad_count, n_checks, nv;

  lqrd_rotation_decoder #(.OSC_TARGET(3), .WINDOW_CYC(40), .IDLE_PERIOD(250),
    .FAST_PERIOD(150), .QUIET_SAMPLES(4)) lqrd_rotation_decoder_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .threshold_comparator_i(threshold_comparator_i),
    .charge_cycles_i(charge_cycles_i), .start_sel_i(start_sel_i), .stop_sel_i(stop_sel_i),
    .single_shot_i(single_shot_i), .arm_i(arm_i), .clear_undersample_i(clear_undersample_i),
    .charge_n_o(charge_n_o), .sensor_pair_state_o(sensor_pair_state_o),
    .forward_step_count_o(forward_step_count_o), .backward_step_count_o(backward_step_count_o),
    .net_rotation_count_o(net_rotation_count_o), .undersample_o(undersample_o),
    .fast_rate_o(fast_rate_o), .sample_done_o(sample_done_o),
    .interval_time_counter_o(interval_time_counter_o), .interval_sensor_o(interval_sensor_o),
    .interval_valid_o(interval_valid_o));
  lqrd_lc_pair lqrd_lc_pair_inst (.core_clk_i(core_clk_i), .charge_n_i(charge_n_o),
    .metal_i(metal), .comp_o(threshold_comparator_i));

  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: seen %0h expected %0h", $time, m, seen, exp);
    end
  endtask
  // Disc moves only between samples; sensor 0 is the state's upper bit
  task automatic step(input logic [1:0] pos);
    int n;
    n = 0;
    metal = {pos[0], pos[1]};
    do begin
      @(posedge core_clk_i);
      #2 n++;
    end while (sample_done_o !== 1'b1 && n < 1000);
    check(sample_done_o, 1, "sample done");
    check(sensor_pair_state_o, pos, "pair state");
  endtask
  task automatic counts(input logic [31:0] f, input logic [31:0] b);
    check(forward_step_count_o, f, "forward count");
    check(backward_step_count_o, b, "backward count");
    @(posedge core_clk_i);
    #2 check(net_rotation_count_o, f - b, "net count");
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset(input logic [1:0] pos);
    @(posedge core_clk_i);
    #2 rst_n_i = 0;
    metal = {pos[0], pos[1]};
    repeat (10) @(posedge core_clk_i);
    #2 check(charge_n_o, 2'h3, "charge idle in reset");
    check(forward_step_count_o | backward_step_count_o, 0, "counts in reset");
    check(undersample_o, 0, "flag in reset");
    rst_n_i = 1;
    step(pos);
    counts(0, 0);
    $display("reset test done");
  endtask
  task automatic t_forward;
    step(2'h1);
    counts(1, 0);
    check(fast_rate_o, 1, "fast on rotation");
    step(2'h3);
    step(2'h2);
    step(2'h0);
    counts(4, 0);
    $display("forward test done");
  endtask
  task automatic t_backward;
    step(2'h2);
    counts(4, 1);
    step(2'h3);
    step(2'h1);
    step(2'h0);
    counts(4, 4);
    $display("backward test done");
  endtask
  task automatic t_jump;
    // Settle back to the slow rate so the jump itself must raise it
    repeat (4) step(2'h0);
    check(fast_rate_o, 0, "slow after quiet");
    step(2'h3);
    counts(4, 4);
    check(undersample_o, 1, "jump flag");
    check(fast_rate_o, 1, "fast rate");
    clear_undersample_i = 1;
    @(posedge core_clk_i);
    #2 clear_undersample_i = 0;
    check(undersample_o, 0, "flag cleared");
    step(2'h1);
    counts(4, 5);
    step(2'h1);
    counts(4, 5);
    $display("jump test done");
  endtask
  task automatic t_interval;
    charge_cycles_i = 8'h00;
    single_shot_i = 1;
    nv = 0;
    step(2'h0);
    check(nv, 0, "capture without arm");
    arm_i = 1;
    step(2'h0);
    arm_i = 0;
    check(nv > 0, 1, "armed capture");
    check(interval_time_counter_o >= 76 && interval_time_counter_o <= 84, 1, "window");
    check(interval_sensor_o, 1, "capture sensor");
    single_shot_i = 0;
    start_sel_i = 1;
    stop_sel_i = 0;
    nv = 0;
    step(2'h0);
    check(nv, 2, "captures per sample");
    check(interval_time_counter_o >= 22 && interval_time_counter_o <= 26, 1, "span");
    $display("interval test done");
  endtask

  // ==========================================
  // Run control
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (interval_valid_o === 1'b1) nv++;
  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out;
  end
  initial begin
    t_reset(2'h0);
    t_forward;
    t_backward;
    t_jump;
    t_interval;
    t_reset(2'h2);
    close_out;
  end
endmodule
